// ### do_seq_top.sv
// Purpose: digital output pattern sequencer, host data to output modules
// Assumes: all inputs synchronous to i_clock, host keeps feeding in
//          non-regeneration mode
// Notes: hardware-timed samples always pass the fifo before reaching o_hw_data
// How it works
// - refuse clock-paced task without buffer
// - host data enters fifo before output
// - finite mode emits set count then halts
// - continuous mode runs until stop request
// - regeneration refills fifo, host writes anytime
// - onboard mode loads once, replays, refuses writes
// - onboard mode only when buffer fits fifo
// - no replay in non-regen, empty flags underflow
// - hardware timing updates on sample clock edge
// - one update per software command
// - parallel module mixes timed and untimed tasks
// - serial module in timed task refuses untimed
// - refuse timed task mixing module types
// - start and pause from terminal or analog
// - high slots shrink parallel fifo space
// - pause lets current sample finish
// - resume at once on onboard clock only
// - start on chosen trigger edge or command
`timescale 1ns/100ps
module do_seq_top #(
    parameter int unsigned W = do_seq_pkg::DATA_W,
    parameter int unsigned DEPTH = do_seq_pkg::FIFO_DEPTH,
    parameter int unsigned IW = do_seq_pkg::IDX_W,
    parameter int unsigned CW = do_seq_pkg::CNT_W,
    parameter int unsigned SW = do_seq_pkg::SCNT_W
) (
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_ce,
    // task configuration and control
    input wire do_seq_pkg::task_cfg_t i_cfg,
    input wire logic [SW-1:0] i_sample_count,
    input wire logic [CW-1:0] i_buffer_len,
    input wire logic i_start_cmd,
    input wire logic i_stop_cmd,
    // host data stream
    input wire logic i_host_valid,
    input wire logic [W-1:0] i_host_data,
    output logic o_host_ready,
    // software-timed write
    input wire logic i_sw_write,
    input wire logic i_sw_serial,
    input wire logic [W-1:0] i_sw_data,
    // timing sources
    input wire logic i_int_sample_clk,
    input wire logic i_ext_sample_clk,
    input wire logic i_pin_start,
    input wire logic i_analog_start,
    input wire logic i_pin_pause,
    input wire logic i_analog_pause,
    // outputs to modules
    output logic [W-1:0] o_hw_data,
    output logic o_hw_update,
    output logic [W-1:0] o_sw_data,
    output logic o_sw_update,
    // status
    output logic o_running,
    output logic o_done,
    output logic o_cfg_error,
    output logic o_underflow,
    output logic o_sw_refused
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN
    } seq_state_t;

    seq_state_t state_ff;
    logic start_lvl_ff;     // previous start source level
    logic clk_lvl_ff;       // previous sample clock level
    logic paused_ff;        // pause in effect
    logic resume_wait_ff;   // waiting for next clock edge to resume
    logic loaded_ff;        // onboard buffer fully loaded
    logic [SW-1:0] sent_ff; // samples emitted in finite mode
    logic [CW-1:0] limit;   // fifo capacity available to this task
    logic cfg_bad;
    logic start_src;
    logic start_edge;
    logic clk_src;
    logic clk_edge;
    logic pause_src;
    logic pause_act;
    logic replay;
    logic fifo_empty;
    logic fifo_full;
    logic [W-1:0] fifo_data;
    logic [CW-1:0] fifo_count;
    logic fifo_wr;
    logic fire;
    logic last;

    // fifo space shrinks for a parallel module in a high slot
    always_comb begin
        limit = CW'(DEPTH);
        if (i_cfg.par_mod && i_cfg.slot >= do_seq_pkg::HIGH_SLOT_FIRST &&
            i_cfg.slot <= do_seq_pkg::HIGH_SLOT_LAST) begin
            limit = CW'(DEPTH) - do_seq_pkg::HIGH_SLOT_LOSS;
        end
    end

    // configuration checks that refuse a timed task
    always_comb begin
        cfg_bad = 1'b0;
        if (i_cfg.hw_timed && !i_cfg.buffered) begin
            cfg_bad = 1'b1;
        end
        if (i_cfg.hw_timed && i_cfg.par_mod && i_cfg.ser_mod) begin
            cfg_bad = 1'b1;
        end
        if (i_cfg.continuous && i_cfg.regen == 2'(do_seq_pkg::MODE_ONBOARD)
            && i_buffer_len > limit) begin
            cfg_bad = 1'b1;
        end
    end

    // trigger and clock source selection
    assign start_src = i_cfg.trig_analog ? i_analog_start : i_pin_start;
    assign pause_src = i_cfg.pause_analog ? i_analog_pause : i_pin_pause;
    assign pause_act = i_cfg.pause_en && (pause_src ^ i_cfg.pause_low);
    assign start_edge = i_cfg.trig_fall ? (start_lvl_ff && !start_src)
                                        : (!start_lvl_ff && start_src);
    assign clk_src = i_cfg.ext_clock ? i_ext_sample_clk : i_int_sample_clk;
    assign clk_edge = clk_src && !clk_lvl_ff;
    assign replay = i_cfg.continuous &&
                    i_cfg.regen == 2'(do_seq_pkg::MODE_ONBOARD) && loaded_ff;
    // sample fires on clock edge, not paused, fifo has data
    assign fire = (state_ff == ST_RUN) && clk_edge && !paused_ff &&
                  !pause_act && !resume_wait_ff && !fifo_empty;
    assign last = !i_cfg.continuous && (sent_ff + 1'b1 == i_sample_count);
    // onboard mode takes no data after load, others take while room
    assign fifo_wr = i_host_valid && o_host_ready;

    do_seq_fifo #(
        .W(W),
        .DEPTH(DEPTH),
        .IW(IW),
        .CW(CW)
    ) u_fifo (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_flush(state_ff == ST_IDLE),
        .i_replay(replay),
        .i_limit(limit),
        .i_wr(fifo_wr),
        .i_wdata(i_host_data),
        .i_rd(fire),
        .o_rdata(fifo_data),
        .o_empty(fifo_empty),
        .o_full(fifo_full),
        .o_count(fifo_count)
    );

    // edge detector history
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            start_lvl_ff <= 1'b0;
            clk_lvl_ff <= 1'b0;
        end else if (i_ce) begin
            start_lvl_ff <= start_src;
            clk_lvl_ff <= clk_src;
        end
    end

    // sequencer state
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            state_ff <= ST_IDLE;
            o_done <= 1'b0;
            o_cfg_error <= 1'b0;
        end else if (i_ce) begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (i_start_cmd) begin
                        o_done <= 1'b0;
                        o_cfg_error <= cfg_bad;
                        if (!cfg_bad && i_cfg.hw_timed) begin
                            state_ff <= i_cfg.use_trig ? ST_ARMED : ST_RUN;
                        end
                    end
                end
                ST_ARMED: begin
                    if (i_stop_cmd) begin
                        state_ff <= ST_IDLE;
                    end else if (start_edge) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (i_stop_cmd) begin
                        state_ff <= ST_IDLE;
                    end else if (fire && last) begin
                        state_ff <= ST_IDLE;
                        o_done <= 1'b1;
                    end
                end
            endcase
        end
    end

    // host ready, onboard load flag
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            loaded_ff <= 1'b0;
            o_host_ready <= 1'b0;
        end else if (i_ce) begin
            if (state_ff == ST_IDLE) begin
                loaded_ff <= 1'b0;
            end else if (i_cfg.continuous &&
                i_cfg.regen == 2'(do_seq_pkg::MODE_ONBOARD) &&
                fifo_count + CW'(fifo_wr) >= i_buffer_len) begin
                loaded_ff <= 1'b1;
            end
            o_host_ready <= (state_ff != ST_IDLE) && !fifo_full && !replay &&
                !(fifo_wr && fifo_count + 1'b1 >= limit) &&
                !(i_cfg.continuous &&
                  i_cfg.regen == 2'(do_seq_pkg::MODE_ONBOARD) &&
                  fifo_count + CW'(fifo_wr) >= i_buffer_len);
        end
    end

    // pause handling and resume policy
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            paused_ff <= 1'b0;
            resume_wait_ff <= 1'b0;
        end else if (i_ce) begin
            paused_ff <= pause_act;
            if (paused_ff && !pause_act && i_cfg.ext_clock) begin
                resume_wait_ff <= 1'b1;
            end else if (clk_edge) begin
                resume_wait_ff <= 1'b0;
            end
        end
    end

    // hardware-timed output and finite count
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_hw_data <= '0;
            o_hw_update <= 1'b0;
            sent_ff <= '0;
            o_running <= 1'b0;
        end else if (i_ce) begin
            o_hw_update <= fire;
            if (fire) begin
                o_hw_data <= fifo_data;
                sent_ff <= sent_ff + 1'b1;
            end
            if (state_ff == ST_IDLE) begin
                sent_ff <= '0;
            end
            o_running <= (state_ff == ST_RUN);
        end
    end

    // underflow: empty fifo on a sample edge in non-regeneration mode
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_underflow <= 1'b0;
        end else if (i_ce) begin
            if (state_ff == ST_RUN && clk_edge && !paused_ff && !pause_act
                && !resume_wait_ff && fifo_empty && i_cfg.continuous &&
                i_cfg.regen == 2'(do_seq_pkg::MODE_NOREGEN)) begin
                o_underflow <= 1'b1;
            end else if (i_start_cmd && state_ff == ST_IDLE) begin
                o_underflow <= 1'b0;
            end
        end
    end

    // software-timed writes, serial module locked while a timed task runs
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_sw_data <= '0;
            o_sw_update <= 1'b0;
            o_sw_refused <= 1'b0;
        end else if (i_ce) begin
            o_sw_update <= 1'b0;
            o_sw_refused <= 1'b0;
            if (i_sw_write) begin
                if (i_sw_serial && state_ff != ST_IDLE) begin
                    o_sw_refused <= 1'b1;
                end else begin
                    o_sw_data <= i_sw_data;
                    o_sw_update <= 1'b1;
                end
            end
        end
    end

    // each accepted command gives an update with its data next cycle
    a_sw_one_update: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && i_sw_write && !(i_sw_serial && state_ff != ST_IDLE)
        |=> o_sw_update && o_sw_data == $past(i_sw_data))
        else $error("software write gave no update");
    a_serial_refused: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && i_sw_write && i_sw_serial && state_ff == ST_RUN
        |=> o_sw_refused && !o_sw_update)
        else $error("serial write taken during timed task");
    a_unbuf_refused: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && state_ff == ST_IDLE && i_start_cmd && i_cfg.hw_timed &&
        !i_cfg.buffered |=> state_ff == ST_IDLE && o_cfg_error)
        else $error("unbuffered timed task started");
    a_mixed_refused: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && state_ff == ST_IDLE && i_start_cmd && i_cfg.hw_timed &&
        i_cfg.par_mod && i_cfg.ser_mod |=> state_ff == ST_IDLE)
        else $error("mixed module timed task started");
    a_finite_halt: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && fire && last && !i_stop_cmd
        |=> state_ff == ST_IDLE ##1 !o_hw_update)
        else $error("finite generation did not halt");
    a_pause_blocks: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && pause_act |=> !o_hw_update)
        else $error("update while paused");
    a_ext_resume: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && $fell(paused_ff) && i_cfg.ext_clock |-> !fire)
        else $error("external clock resumed without edge");
    a_onboard_closed: assert property (@(posedge i_clock)
        disable iff (!i_nrst) replay |-> !fifo_wr)
        else $error("fifo written after onboard load");
    a_underflow_flag: assert property (@(posedge i_clock)
        disable iff (!i_nrst) i_ce && state_ff == ST_RUN && clk_edge &&
        !paused_ff && !pause_act && !resume_wait_ff && fifo_empty &&
        i_cfg.continuous && i_cfg.regen == 2'(do_seq_pkg::MODE_NOREGEN)
        |=> o_underflow)
        else $error("underflow not flagged");
endmodule

// ### do_seq_pkg.sv
// Purpose: shared constants and types for the output pattern sequencer
// Assumes: one 20 MHz clock, synchronous inputs
// Notes: fifo depth and widths are defaults, sized by module parameters
package do_seq_pkg;
    // data width of one output sample
    localparam int unsigned DATA_W = 8;
    // fifo depth in samples (full capacity, low slots)
    localparam int unsigned FIFO_DEPTH = 16;
    // index width of the fifo
    localparam int unsigned IDX_W = 4;
    // count width, one more than index
    localparam int unsigned CNT_W = 5;
    // finite sample count width
    localparam int unsigned SCNT_W = 16;
    // fifo space lost by a parallel module in a high slot
    localparam logic [CNT_W-1:0] HIGH_SLOT_LOSS = 5'h08;
    // first slot number that counts as a high slot
    localparam logic [3:0] HIGH_SLOT_FIRST = 4'h5;
    // last valid slot number
    localparam logic [3:0] HIGH_SLOT_LAST = 4'h8;
    // clock rate of the sequencer clock i_clock
    localparam int unsigned CLK_HZ = 20000000;
    // continuous data modes
    typedef enum logic [1:0] {
        MODE_REGEN,
        MODE_ONBOARD,
        MODE_NOREGEN
    } regen_mode_t;
    // task configuration as one carrier
    typedef struct packed {
        logic hw_timed;     // clock-paced task
        logic buffered;     // task uses the buffer
        logic continuous;   // continuous sample mode
        logic [1:0] regen;  // regen_mode_t value
        logic ext_clock;    // sample clock from external input
        logic use_trig;     // wait for start trigger edge
        logic trig_fall;    // start on falling edge
        logic trig_analog;  // start source is analog comparison
        logic pause_en;     // pause trigger in use
        logic pause_low;    // pause active when low
        logic pause_analog; // pause source is analog comparison
        logic par_mod;      // task uses a parallel-type module
        logic ser_mod;      // task uses a serial-type module
        logic [3:0] slot;   // slot of a parallel module
    } task_cfg_t;
endpackage

// ### do_seq_fifo.sv
// Purpose: flip-flop fifo with optional replay of its loaded content
// Assumes: writes and reads are gated by the caller
// Notes: replay keeps data, the read index wraps to the first sample
`timescale 1ns/100ps
module do_seq_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned IW = 4,
    parameter int unsigned CW = 5
) (
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_ce,
    // control
    input wire logic i_flush,
    input wire logic i_replay,
    input wire logic [CW-1:0] i_limit,
    // write side
    input wire logic i_wr,
    input wire logic [W-1:0] i_wdata,
    // read side
    input wire logic i_rd,
    output logic [W-1:0] o_rdata,
    output logic o_empty,
    output logic o_full,
    output logic [CW-1:0] o_count
);
    logic [W-1:0] mem_ff [DEPTH]; // sample storage
    logic [IW-1:0] wr_ff;         // write index
    logic [IW-1:0] rd_ff;         // read index
    logic [CW-1:0] cnt_ff;        // samples held (or loaded, in replay)
    logic [CW-1:0] pos_ff;        // replay position
    logic do_wr;
    logic do_rd;

    assign o_empty = (cnt_ff == '0);
    assign o_full = (cnt_ff >= i_limit);
    assign o_count = cnt_ff;
    assign o_rdata = mem_ff[rd_ff];
    assign do_wr = i_wr && !o_full && !i_replay;
    assign do_rd = i_rd && !o_empty;

    // storage write
    always_ff @(posedge i_clock) begin
        if (i_ce && do_wr) begin
            mem_ff[wr_ff] <= i_wdata;
        end
    end

    // indices and count
    always_ff @(posedge i_clock) begin
        if (!i_nrst || (i_ce && i_flush)) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            pos_ff <= '0;
        end else if (i_ce) begin
            if (do_wr) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (i_replay) begin
                // wrap to first loaded sample after the last
                if (do_rd) begin
                    if (pos_ff + 1'b1 >= cnt_ff) begin
                        pos_ff <= '0;
                        rd_ff <= '0;
                    end else begin
                        pos_ff <= pos_ff + 1'b1;
                        rd_ff <= rd_ff + 1'b1;
                    end
                end
            end else begin
                if (do_rd) begin
                    rd_ff <= rd_ff + 1'b1;
                end
                cnt_ff <= cnt_ff + CW'(do_wr) - CW'(do_rd);
            end
        end
    end
endmodule

// ### do_seq_host_model.sv
// Purpose: host feeder and sample clock sources for the sequencer
// Assumes: o_host_ready of the sequencer is registered
// Notes: sample clocks stand low while disabled
`timescale 1ns/100ps
module do_seq_host_model (
    // clock and controls
    input wire logic i_clock,
    input wire logic i_feed_en,
    input wire logic i_clk_en,
    // host stream
    input wire logic i_ready,
    output logic o_valid,
    output logic [7:0] o_data,
    // sample clock levels
    output logic o_int_clk,
    output logic o_ext_clk
);
    integer seed = 32'h99AAA5F1; // fixed seed
    int cnt = 0; // cycles since clocks enabled
    logic rdy; // ready seen at the edge
    // quiet start
    initial begin
        o_valid = 1'b0;
        o_data = 8'h00;
        o_int_clk = 1'b0;
        o_ext_clk = 1'b0;
    end
    // word held until taken; idle data toggles every cycle
    always @(posedge i_clock) begin
        rdy = i_ready;
        #1;
        if (!o_valid || rdy) begin
            o_valid = i_feed_en;
            o_data = i_feed_en ? 8'($random(seed)) : ~o_data;
        end
    end
    // internal period 8 cycles, external period 10 cycles
    always @(posedge i_clock) begin
        #1;
        cnt = i_clk_en ? cnt + 1 : 0;
        o_int_clk = i_clk_en && (cnt % 8 >= 4);
        o_ext_clk = i_clk_en && (cnt % 10 >= 5);
    end
endmodule

// ### tb_top.sv
// Purpose: self-checking bench of the output pattern sequencer
// Assumes: one 50 ns clock, reset held for 10 cycles
// Notes: model compares every sample update with the host words
`timescale 1ns/100ps
module tb_top;
    // stimulus
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    do_seq_pkg::task_cfg_t cfg;
    logic [15:0] count = 16'h0001;
    logic [4:0] buf_len = 5'h01;
    logic start_cmd = 1'b0;
    logic stop_cmd = 1'b0;
    logic sw_write = 1'b0;
    logic sw_serial = 1'b0;
    logic [7:0] sw_data = 8'h00;
    logic feed_en = 1'b0;
    logic clk_en = 1'b0;
    logic pin_start = 1'b0;
    logic ana_start = 1'b0;
    logic pin_pause = 1'b0;
    // observed signals
    logic host_valid, host_ready, int_clk, ext_clk;
    logic [7:0] host_data, hw_data, sw_out;
    logic hw_upd, sw_upd, running, done, cfg_err, underflow, refused;
    // scoreboard
    int num_errors = 0;
    int check_count = 0;
    logic [15:0] updates = 16'h0000;
    logic [15:0] sw_updates = 16'h0000;
    logic [15:0] refusals = 16'h0000;
    logic [15:0] accepted = 16'h0000;
    logic [15:0] idx = 16'h0000;
    logic [7:0] exp_q[$];
    logic [7:0] load_mem[32];
    logic onboard = 1'b0;
    logic [4:0] lens[8] = '{5'h01, 5'h01, 5'h09, 5'h08,
                            5'h10, 5'h11, 5'h01, 5'h01};
    logic [7:0] errs = 8'h27; // set-ups that must be refused
    logic [7:0] runs = 8'h58; // set-ups that must run

    always #25 i_clock = ~i_clock;

    do_seq_top do_seq_top_inst (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_ce(1'b1),
        .i_cfg(cfg), .i_sample_count(count), .i_buffer_len(buf_len),
        .i_start_cmd(start_cmd), .i_stop_cmd(stop_cmd),
        .i_host_valid(host_valid), .i_host_data(host_data),
        .o_host_ready(host_ready),
        .i_sw_write(sw_write), .i_sw_serial(sw_serial),
        .i_sw_data(sw_data),
        .i_int_sample_clk(int_clk), .i_ext_sample_clk(ext_clk),
        .i_pin_start(pin_start), .i_analog_start(ana_start),
        .i_pin_pause(pin_pause), .i_analog_pause(1'b0),
        .o_hw_data(hw_data), .o_hw_update(hw_upd),
        .o_sw_data(sw_out), .o_sw_update(sw_upd),
        .o_running(running), .o_done(done), .o_cfg_error(cfg_err),
        .o_underflow(underflow), .o_sw_refused(refused)
    );

    do_seq_host_model do_seq_host_model_inst (
        .i_clock(i_clock), .i_feed_en(feed_en), .i_clk_en(clk_en),
        .i_ready(host_ready), .o_valid(host_valid),
        .o_data(host_data), .o_int_clk(int_clk), .o_ext_clk(ext_clk)
    );

    // compare and count
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic wrap_up();
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // reference model: host words in order, onboard replay wraps
    always @(posedge i_clock) begin
        if (i_nrst && host_valid && host_ready) begin
            if (onboard) load_mem[accepted] = host_data;
            else exp_q.push_back(host_data);
            accepted++;
        end
        if (i_nrst && hw_upd) begin
            updates++;
            if (onboard) begin
                check("replay", load_mem[idx % buf_len], hw_data);
                idx++;
            end else if (exp_q.size() == 0) begin
                check("replayed word", 16'h0000, 16'h0001);
            end else begin
                check("hw data", exp_q.pop_front(), hw_data);
            end
        end
        if (i_nrst && sw_upd) sw_updates++;
        if (i_nrst && refused) refusals++;
    end

    // wait n edges, then drive just after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    // default clock-paced buffered set-up on a low-slot parallel module
    function automatic do_seq_pkg::task_cfg_t base();
        do_seq_pkg::task_cfg_t c;
        c = '0;
        c.hw_timed = 1'b1;
        c.buffered = 1'b1;
        c.par_mod = 1'b1;
        c.slot = 4'h1;
        return c;
    endfunction

    // load set-up, clear the model, pulse start
    task automatic go(input do_seq_pkg::task_cfg_t c);
        cfg = c;
        exp_q.delete();
        accepted = 16'h0000;
        idx = 16'h0000;
        updates = 16'h0000;
        onboard = c.continuous && c.regen == do_seq_pkg::MODE_ONBOARD;
        start_cmd = 1'b1;
        cyc(1);
        start_cmd = 1'b0;
    endtask

    // stop request, sources quiet
    task automatic halt();
        stop_cmd = 1'b1;
        cyc(1);
        stop_cmd = 1'b0;
        clk_en = 1'b0;
        feed_en = 1'b0;
        cyc(3);
    endtask

    // bounded wait for a number of sample updates
    task automatic wait_upd(input logic [15:0] target, input int n);
        for (int k = 0; k < n && updates < target; k++) cyc(1);
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge i_clock);
        num_errors++;
        wrap_up();
    end

    initial begin
        do_seq_pkg::task_cfg_t c;
        logic [15:0] u0;
        logic [15:0] r0;
        cfg = base();
        cyc(10);
        i_nrst = 1'b1;
        cyc(1);
        check("running", 16'h0000, 16'(running));
        check("host ready", 16'h0000, 16'(host_ready));
        // refused and accepted set-ups
        for (int i = 0; i < 8; i++) begin
            c = base();
            c.continuous = 1'b1;
            c.slot = (i == 2 || i == 3) ? 4'h5 : 4'h2;
            case (i)
                0: c.buffered = 1'b0;
                1: c.ser_mod = 1'b1;
                6: {c.par_mod, c.ser_mod} = 2'b01;
                7: c.hw_timed = 1'b0;
                default: c.regen = do_seq_pkg::MODE_ONBOARD;
            endcase
            buf_len = lens[i];
            go(c);
            cyc(3);
            check("cfg error", 16'(errs[i]), 16'(cfg_err));
            check("running", 16'(runs[i]), 16'(running));
            halt();
        end
        // finite runs: one sample internal, seven samples external
        for (int e = 0; e < 2; e++) begin
            c = base();
            c.ext_clock = e[0];
            count = e ? 16'h0007 : 16'h0001;
            feed_en = 1'b1;
            go(c);
            cyc(4);
            clk_en = 1'b1;
            for (int k = 0; k < 300 && done !== 1'b1; k++) cyc(1);
            check("done", 16'h0001, 16'(done));
            cyc(40);
            check("finite count", count, updates);
            check("running", 16'h0000, 16'(running));
            halt();
        end
        // start edge on each source and polarity, wrong source first
        for (int t = 0; t < 4; t++) begin
            c = base();
            c.continuous = 1'b1;
            c.use_trig = 1'b1;
            c.trig_fall = t[0];
            c.trig_analog = t[1];
            pin_start = t[0];
            ana_start = t[0];
            feed_en = 1'b1;
            clk_en = 1'b1;
            cyc(2);
            go(c);
            cyc(20);
            if (t[1]) pin_start = ~t[0];
            else ana_start = ~t[0];
            cyc(20);
            check("armed updates", 16'h0000, updates);
            if (t[1]) ana_start = ~t[0];
            else pin_start = ~t[0];
            wait_upd(16'h0006, 120);
            check("running", 16'h0001, 16'(running));
            check("done", 16'h0000, 16'(done));
            halt();
            u0 = updates;
            cyc(30);
            check("after stop", u0, updates);
            check("running", 16'h0000, 16'(running));
            pin_start = 1'b0;
            ana_start = 1'b0;
        end
        // onboard: five words loaded once, replayed round and round
        c = base();
        c.continuous = 1'b1;
        c.regen = do_seq_pkg::MODE_ONBOARD;
        buf_len = 5'h05;
        feed_en = 1'b1;
        go(c);
        cyc(30);
        check("loaded", 16'h0005, accepted);
        check("host ready", 16'h0000, 16'(host_ready));
        clk_en = 1'b1;
        wait_upd(16'h000C, 200);
        check("replays", 16'h000C, updates);
        check("loaded", 16'h0005, accepted);
        halt();
        // non-regeneration: host stops feeding, fifo runs dry
        c.regen = do_seq_pkg::MODE_NOREGEN;
        feed_en = 1'b1;
        go(c);
        cyc(4);
        clk_en = 1'b1;
        wait_upd(16'h0004, 100);
        check("underflow", 16'h0000, 16'(underflow));
        feed_en = 1'b0;
        for (int k = 0; k < 300 && underflow !== 1'b1; k++) cyc(1);
        check("underflow", 16'h0001, 16'(underflow));
        halt();
        // pause and resume on both clock sources
        for (int e = 0; e < 2; e++) begin
            c = base();
            c.continuous = 1'b1;
            c.pause_en = 1'b1;
            c.ext_clock = e[0];
            feed_en = 1'b1;
            go(c);
            cyc(4);
            clk_en = 1'b1;
            wait_upd(16'h0002, 100);
            pin_pause = 1'b1;
            cyc(2);
            u0 = updates;
            cyc(40);
            check("paused", u0, updates);
            pin_pause = 1'b0;
            wait_upd(u0 + 16'h0001, e ? 30 : 12);
            check("resumed", u0 + 16'h0001, updates);
            halt();
        end
        // software writes: idle serial, running parallel, running serial
        for (int s = 0; s < 3; s++) begin
            if (s == 1) go(base());
            cyc(3);
            u0 = sw_updates;
            r0 = refusals;
            sw_serial = s != 1;
            sw_data = 8'h3C + 8'(s);
            sw_write = 1'b1;
            cyc(1);
            sw_write = 1'b0;
            cyc(3);
            check("sw updates", u0 + 16'(s != 2), sw_updates);
            check("sw refused", r0 + 16'(s == 2), refusals);
            if (s != 2) check("sw data", 16'(sw_data), 16'(sw_out));
        end
        halt();
        wrap_up();
    end
endmodule
